// ==== flash_row_write_sequencer.sv ====
// self-programming row write sequencer with AXI4-Lite registers
// Overview of operation
// - address above low six bits selects row
// - program never crosses the selected row
// - latches blank to 3FFF after program
// - latches blank after erase; unloaded stay blank
// - program start does no erase
// - erase always exactly one row
// - at most 64 words per program
// - latch-only set: unlock copies data to latch
// - latch-only clear: load last, program row
// - no load or program without unlock
// - interrupted unlock loads and programs nothing
// - region select steers to alternate region
// - user IDs, EEPROM read-write; IDs read only
// - config, calibration read only; rest none
// - bad alternate read clears data pair
// - error flag on protect, one-cycle reset, interruption
// - latch load ignores protect; protected program errors
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_regs.svh"
module flash_row_write_sequencer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [5:0] s_awaddr,
	input wire logic [2:0] s_awprot,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [5:0] s_araddr,
	input wire logic [2:0] s_arprot,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	input wire logic [8:0] wp_rows,
	output logic [14:0] flash_addr,
	output logic flash_region,
	output logic [13:0] flash_wdata,
	output logic flash_wr,
	output logic flash_erase,
	output logic flash_rd,
	input wire logic flash_done,
	input wire logic [13:0] flash_rdata
);
	latch_if lif();
	flash_seq_pkg::state_t state_r, state_nxt;
	flash_seq_pkg::unlock_t ul_r, ul_nxt;
	logic [14:0] addr_r, addr_nxt; // address pair
	logic [13:0] data_r, data_nxt; // data pair
	logic regsel_r, regsel_nxt, latch_only_sel_r, latch_only_sel_nxt, free_r, free_nxt;
	logic write_enable_bit_r, write_enable_bit_nxt, write_error_flag_r, write_error_flag_nxt;
	logic [5:0] idx_r, idx_nxt; // latch walk index
	logic [14:0] fa_r, fa_nxt;
	logic [13:0] fd_r, fd_nxt;
	logic freg_r, freg_nxt, fwr_r, fwr_nxt, fer_r, fer_nxt, frd_r, frd_nxt;
	logic aw_h_r, aw_h_nxt, w_h_r, w_h_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
	logic [5:0] aw_a_r, aw_a_nxt;
	logic [7:0] wb_r, wb_nxt; // only the low byte is implemented
	logic wen_r, wen_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic do_wr, busy, wr_busy, rd_busy, start, rd_req, hw_err, prot;
	logic alt_rd_ok, alt_wr_ok;
	logic [2:0] wsel;
	logic [7:0] ctl_rb;

	// map a byte address to a register number, 7 when unmapped
	function automatic logic [2:0] reg_sel(input logic [5:0] a);
		case (a)
			`FRS_OFF_ADDR_LO: reg_sel = 3'h0;
			`FRS_OFF_ADDR_HI: reg_sel = 3'h1;
			`FRS_OFF_DATA_LO: reg_sel = 3'h2;
			`FRS_OFF_DATA_HI: reg_sel = 3'h3;
			`FRS_OFF_CTRL: reg_sel = 3'h4;
			`FRS_OFF_KEY: reg_sel = 3'h5;
			default: reg_sel = 3'h7;
		endcase
	endfunction

	latch_buffer #(.DEPTH(64)) u_latch (.aclk(aclk), .aresetn(aresetn), .lif(lif.mem));
	region_check u_region (.addr(addr_r), .rd_ok(alt_rd_ok), .wr_ok(alt_wr_ok));

	// handshake and status decode
	always_comb begin
		busy = state_r != flash_seq_pkg::ST_IDLE;
		rd_busy = state_r == flash_seq_pkg::ST_RD || state_r == flash_seq_pkg::ST_RD_WAIT;
		wr_busy = busy && !rd_busy; // start bit reads back as write in flight
		s_awready = !aw_h_r && !bv_r;
		s_wready = !w_h_r && !bv_r;
		s_arready = !rv_r;
		do_wr = aw_h_r && w_h_r && !bv_r;
		wsel = reg_sel(aw_a_r);
		prot = addr_r[14:6] < wp_rows;
		ctl_rb = {1'b0, regsel_r, latch_only_sel_r, free_r, write_error_flag_r, write_enable_bit_r, wr_busy, rd_busy};
	end

	// bus slave: write address and data taken in either order
	always_comb begin
		aw_h_nxt = aw_h_r;
		w_h_nxt = w_h_r;
		aw_a_nxt = aw_a_r;
		wb_nxt = wb_r;
		wen_nxt = wen_r;
		bv_nxt = bv_r;
		br_nxt = br_r;
		rv_nxt = rv_r;
		rr_nxt = rr_r;
		rd_nxt = rd_r;
		if (s_awvalid && s_awready) begin
			aw_h_nxt = 1'b1;
			aw_a_nxt = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			w_h_nxt = 1'b1;
			wb_nxt = s_wdata[7:0];
			wen_nxt = s_wstrb[0];
		end
		if (do_wr) begin
			aw_h_nxt = 1'b0;
			w_h_nxt = 1'b0;
			bv_nxt = 1'b1;
			br_nxt = (wsel == 3'h7) ? 2'h2 : 2'h0; // unmapped answers SLVERR
		end
		if (bv_r && s_bready)
			bv_nxt = 1'b0;
		if (rv_r && s_rready)
			rv_nxt = 1'b0;
		if (s_arvalid && s_arready) begin
			rv_nxt = 1'b1;
			rr_nxt = 2'h0;
			case (reg_sel(s_araddr))
				3'h0: rd_nxt = {24'h000000, addr_r[7:0]};
				3'h1: rd_nxt = {24'h000000, 1'b1, addr_r[14:8]};
				3'h2: rd_nxt = {24'h000000, data_r[7:0]};
				3'h3: rd_nxt = {26'h0000000, data_r[13:8]};
				3'h4: rd_nxt = {24'h000000, ctl_rb};
				3'h5: rd_nxt = 32'h00000000; // key register reads zero
				default: begin
					rd_nxt = 32'h00000000;
					rr_nxt = 2'h2;
				end
			endcase
		end
	end

	// register writes, unlock tracking and the sequencer
	always_comb begin
		state_nxt = state_r;
		ul_nxt = ul_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		regsel_nxt = regsel_r;
		latch_only_sel_nxt = latch_only_sel_r;
		free_nxt = free_r;
		write_enable_bit_nxt = write_enable_bit_r;
		write_error_flag_nxt = write_error_flag_r;
		idx_nxt = idx_r;
		fa_nxt = fa_r;
		fd_nxt = fd_r;
		freg_nxt = freg_r;
		fwr_nxt = 1'b0;
		fer_nxt = 1'b0;
		frd_nxt = 1'b0;
		lif.wr_en = 1'b0;
		lif.wr_idx = addr_r[5:0];
		lif.wr_data = data_r;
		lif.rd_idx = idx_r;
		lif.blank = 1'b0;
		start = 1'b0;
		rd_req = 1'b0;
		hw_err = 1'b0;
		// writes are ignored while an operation runs, which also freezes the address
		if (do_wr && wen_r && !busy) begin
			case (wsel)
				3'h0: addr_nxt[7:0] = wb_r;
				3'h1: addr_nxt[14:8] = wb_r[6:0];
				3'h2: data_nxt[7:0] = wb_r;
				3'h3: data_nxt[13:8] = wb_r[5:0];
				3'h4: begin
					regsel_nxt = wb_r[`FRS_B_REGSEL];
					latch_only_sel_nxt = wb_r[`FRS_B_LATCH_ONLY_SEL];
					free_nxt = wb_r[`FRS_B_FREE];
					write_enable_bit_nxt = wb_r[`FRS_B_WRITE_ENABLE_BIT];
					write_error_flag_nxt = wb_r[`FRS_B_WRITE_ERROR_FLAG];
					rd_req = wb_r[`FRS_B_RD] && !wb_r[`FRS_B_WR];
				end
				default: ;
			endcase
			// key steps must arrive as consecutive writes
			case (ul_r)
				flash_seq_pkg::UL_IDLE: begin
					if (wsel == 3'h5 && wb_r == `FRS_KEY_FIRST)
						ul_nxt = flash_seq_pkg::UL_KEY1;
				end
				flash_seq_pkg::UL_KEY1: begin
					if (wsel == 3'h5 && wb_r == `FRS_KEY_SECOND) begin
						ul_nxt = flash_seq_pkg::UL_KEY2;
					end else begin
						ul_nxt = flash_seq_pkg::UL_IDLE;
						hw_err = 1'b1;
					end
				end
				flash_seq_pkg::UL_KEY2: begin
					ul_nxt = flash_seq_pkg::UL_IDLE;
					if (wsel == 3'h4 && wb_r[`FRS_B_WR] && wb_r[`FRS_B_WRITE_ENABLE_BIT])
						start = 1'b1;
					else
						hw_err = 1'b1;
				end
				default: ul_nxt = flash_seq_pkg::UL_IDLE;
			endcase
		end
		// operation launch uses the freshly written control bits
		if (start) begin
			if (regsel_nxt) begin
				if (alt_wr_ok)
					state_nxt = flash_seq_pkg::ST_AWR;
				else
					hw_err = 1'b1;
			end else if (free_nxt) begin
				if (prot)
					hw_err = 1'b1;
				else
					state_nxt = flash_seq_pkg::ST_ERASE;
			end else begin
				lif.wr_en = 1'b1;
				if (!latch_only_sel_nxt) begin
					idx_nxt = 6'h00;
					if (prot)
						hw_err = 1'b1;
					else
						state_nxt = flash_seq_pkg::ST_PRG_RD;
				end
			end
		end else if (rd_req) begin
			if (regsel_nxt && !alt_rd_ok)
				data_nxt = 14'h0000;
			else
				state_nxt = flash_seq_pkg::ST_RD;
		end
		case (state_r)
			flash_seq_pkg::ST_IDLE: ;
			flash_seq_pkg::ST_PRG_RD: state_nxt = flash_seq_pkg::ST_PRG_WR;
			flash_seq_pkg::ST_PRG_WR: begin
				fwr_nxt = 1'b1;
				freg_nxt = 1'b0;
				fa_nxt = {addr_r[14:6], idx_r};
				fd_nxt = lif.rd_data;
				state_nxt = flash_seq_pkg::ST_PRG_WAIT;
			end
			flash_seq_pkg::ST_PRG_WAIT: begin
				if (flash_done) begin
					if (idx_r == `FRS_LAST_IDX) begin
						lif.blank = 1'b1;
						state_nxt = flash_seq_pkg::ST_IDLE;
					end else begin
						idx_nxt = idx_r + 6'h01;
						state_nxt = flash_seq_pkg::ST_PRG_RD;
					end
				end
			end
			flash_seq_pkg::ST_ERASE: begin
				fer_nxt = 1'b1;
				freg_nxt = 1'b0;
				fa_nxt = {addr_r[14:6], 6'h00};
				state_nxt = flash_seq_pkg::ST_ERASE_WAIT;
			end
			flash_seq_pkg::ST_ERASE_WAIT: begin
				if (flash_done) begin
					lif.blank = 1'b1;
					free_nxt = 1'b0;
					state_nxt = flash_seq_pkg::ST_IDLE;
				end
			end
			flash_seq_pkg::ST_RD: begin
				frd_nxt = 1'b1;
				freg_nxt = regsel_r;
				fa_nxt = addr_r;
				state_nxt = flash_seq_pkg::ST_RD_WAIT;
			end
			flash_seq_pkg::ST_RD_WAIT: begin
				if (flash_done) begin
					data_nxt = flash_rdata;
					state_nxt = flash_seq_pkg::ST_IDLE;
				end
			end
			flash_seq_pkg::ST_AWR: begin
				fwr_nxt = 1'b1;
				freg_nxt = 1'b1;
				fa_nxt = addr_r;
				fd_nxt = data_r;
				state_nxt = flash_seq_pkg::ST_AWR_WAIT;
			end
			flash_seq_pkg::ST_AWR_WAIT: begin
				if (flash_done)
					state_nxt = flash_seq_pkg::ST_IDLE;
			end
			default: state_nxt = flash_seq_pkg::ST_IDLE;
		endcase
		if (hw_err)
			write_error_flag_nxt = 1'b1;
	end

	// registers; a one-cycle reset during a write or erase leaves the error flag set, a longer one clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= flash_seq_pkg::ST_IDLE;
			ul_r <= flash_seq_pkg::UL_IDLE;
			write_error_flag_r <= wr_busy;
			addr_r <= 15'h0000;
			data_r <= 14'h0000;
			{regsel_r, latch_only_sel_r, free_r, write_enable_bit_r} <= 4'h0;
			idx_r <= 6'h00;
			fa_r <= 15'h0000;
			fd_r <= 14'h0000;
			{freg_r, fwr_r, fer_r, frd_r} <= 4'h0;
			{aw_h_r, w_h_r, bv_r, rv_r, wen_r} <= 5'h00;
			aw_a_r <= 6'h00;
			wb_r <= 8'h00;
			br_r <= 2'h0;
			rr_r <= 2'h0;
			rd_r <= 32'h00000000;
		end else begin
			state_r <= state_nxt;
			ul_r <= ul_nxt;
			write_error_flag_r <= write_error_flag_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			{regsel_r, latch_only_sel_r, free_r, write_enable_bit_r} <= {regsel_nxt, latch_only_sel_nxt, free_nxt, write_enable_bit_nxt};
			idx_r <= idx_nxt;
			fa_r <= fa_nxt;
			fd_r <= fd_nxt;
			{freg_r, fwr_r, fer_r, frd_r} <= {freg_nxt, fwr_nxt, fer_nxt, frd_nxt};
			{aw_h_r, w_h_r, bv_r, rv_r, wen_r} <= {aw_h_nxt, w_h_nxt, bv_nxt, rv_nxt, wen_nxt};
			aw_a_r <= aw_a_nxt;
			wb_r <= wb_nxt;
			br_r <= br_nxt;
			rr_r <= rr_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign s_bvalid = bv_r;
	assign s_bresp = br_r;
	assign s_rvalid = rv_r;
	assign s_rresp = rr_r;
	assign s_rdata = rd_r;
	assign flash_addr = fa_r;
	assign flash_region = freg_r;
	assign flash_wdata = fd_r;
	assign flash_wr = fwr_r;
	assign flash_erase = fer_r;
	assign flash_rd = frd_r;

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_ROW_BOUND: assert property (fwr_r && !freg_r |-> fa_r[14:6] == addr_r[14:6])
		else $error("program left the row");
	AST_PRG_BLANK: assert property (state_r == flash_seq_pkg::ST_PRG_WAIT && flash_done
		&& idx_r == 6'h3F |-> lif.blank ##1 state_r == flash_seq_pkg::ST_IDLE)
		else $error("latches not blanked after program");
	AST_ERASE_BLANK: assert property (state_r == flash_seq_pkg::ST_ERASE_WAIT && flash_done
		|-> lif.blank)
		else $error("latches not blanked after erase");
	AST_NO_ERASE: assert property (state_r inside {flash_seq_pkg::ST_PRG_RD,
		flash_seq_pkg::ST_PRG_WR, flash_seq_pkg::ST_PRG_WAIT} |-> !fer_r)
		else $error("erase during program");
	AST_LATCH_ONLY: assert property (start && !regsel_nxt && !free_nxt && latch_only_sel_nxt
		|-> lif.wr_en ##1 !busy ##1 !fwr_r)
		else $error("latch load started flash activity");
	AST_PRG_GO: assert property (start && !regsel_nxt && !free_nxt && !latch_only_sel_nxt && !prot
		|=> state_r == flash_seq_pkg::ST_PRG_RD ##2 fwr_r)
		else $error("program did not start");
	AST_KEYED: assert property ($rose(wr_busy) |-> $past(ul_r) == flash_seq_pkg::UL_KEY2)
		else $error("write started without unlock");
	AST_BROKEN_KEY: assert property (ul_r == flash_seq_pkg::UL_KEY1 && do_wr && wen_r
		&& !busy && !(wsel == 3'h5 && wb_r == 8'hAA) |=> write_error_flag_r && !busy)
		else $error("interrupted unlock not flagged");
	AST_BAD_READ: assert property (rd_req && regsel_nxt && !alt_rd_ok
		|=> data_r == 14'h0000 && !frd_r)
		else $error("bad read did not clear data");
	AST_ALT_DENY: assert property (start && regsel_nxt && !alt_wr_ok
		|=> write_error_flag_r && !busy)
		else $error("alternate write not refused");
	AST_PROT_PRG: assert property (start && !regsel_nxt && !free_nxt && !latch_only_sel_nxt && prot
		|=> write_error_flag_r && !wr_busy)
		else $error("protected program not refused");
	COV_ROW: cover property (state_r == flash_seq_pkg::ST_PRG_WAIT && flash_done && idx_r == 6'h3F);
	COV_ERASE: cover property (state_r == flash_seq_pkg::ST_ERASE_WAIT && flash_done);
	COV_LOAD: cover property (start && latch_only_sel_nxt && !regsel_nxt);
	COV_ALT_RD: cover property (state_r == flash_seq_pkg::ST_RD_WAIT && flash_done && regsel_r);
endmodule
`default_nettype wire

// ==== flash_seq_regs.svh ====
// register offsets, control bit positions and fixed values of the row write sequencer
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH
`define FRS_OFF_ADDR_LO 6'h00
`define FRS_OFF_ADDR_HI 6'h04
`define FRS_OFF_DATA_LO 6'h08
`define FRS_OFF_DATA_HI 6'h0C
`define FRS_OFF_CTRL 6'h10
`define FRS_OFF_KEY 6'h14
`define FRS_B_RD 0
`define FRS_B_WR 1
`define FRS_B_WRITE_ENABLE_BIT 2
`define FRS_B_WRITE_ERROR_FLAG 3
`define FRS_B_FREE 4
`define FRS_B_LATCH_ONLY_SEL 5
`define FRS_B_REGSEL 6
`define FRS_KEY_FIRST 8'h55
`define FRS_KEY_SECOND 8'hAA
`define FRS_BLANK 14'h3FFF
`define FRS_LAST_IDX 6'h3F
`define FRS_UID_LO 16'h8000
`define FRS_UID_HI 16'h8003
`define FRS_ID_LO 16'h8005
`define FRS_ID_HI 16'h8006
`define FRS_CFG_LO 16'h8007
`define FRS_CFG_HI 16'h800B
`define FRS_INFO_LO 16'h8100
`define FRS_INFO_HI 16'h82FF
`define FRS_EE_LO 16'hF000
`define FRS_EE_HI 16'hF0FF
`endif

// ==== flash_seq_pkg.sv ====
// types shared by the row write sequencer modules
`default_nettype none
package flash_seq_pkg;
	// sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_PRG_RD = 4'h1,
		ST_PRG_WR = 4'h2,
		ST_PRG_WAIT = 4'h3,
		ST_ERASE = 4'h4,
		ST_ERASE_WAIT = 4'h5,
		ST_RD = 4'h6,
		ST_RD_WAIT = 4'h7,
		ST_AWR = 4'h8,
		ST_AWR_WAIT = 4'h9
	} state_t;
	// unlock key progress
	typedef enum logic [1:0] {
		UL_IDLE = 2'h0,
		UL_KEY1 = 2'h1,
		UL_KEY2 = 2'h2
	} unlock_t;
endpackage
`default_nettype wire

// ==== latch_if.sv ====
// interface between sequencer and write latch buffer
`timescale 1ns/10ps
`default_nettype none
interface latch_if;
	logic wr_en; // store one latch word
	logic [5:0] wr_idx;
	logic [13:0] wr_data;
	logic [5:0] rd_idx;
	logic [13:0] rd_data; // registered read data
	logic blank; // return every latch to blank
	modport ctl(output wr_en, wr_idx, wr_data, rd_idx, blank, input rd_data);
	modport mem(input wr_en, wr_idx, wr_data, rd_idx, blank, output rd_data);
endinterface
`default_nettype wire

// ==== latch_buffer.sv ====
// row write latch buffer with single-cycle blanking
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_regs.svh"
module latch_buffer #(
	parameter int DEPTH = 64
) (
	input wire logic aclk,
	input wire logic aresetn,
	latch_if.mem lif
);
	logic [13:0] mem_r [DEPTH]; // word store, no reset needed
	logic [DEPTH-1:0] valid_r; // per-latch loaded flag
	logic [DEPTH-1:0] valid_nxt;
	logic [13:0] rd_data_r;
	logic [13:0] rd_data_nxt;

	// blank clears valid flags only, so blanking costs one cycle not 64
	always_comb begin
		valid_nxt = valid_r;
		if (lif.wr_en)
			valid_nxt[lif.wr_idx] = 1'b1;
		if (lif.blank)
			valid_nxt = '0;
		rd_data_nxt = valid_r[lif.rd_idx] ? mem_r[lif.rd_idx] : `FRS_BLANK;
	end

	// state registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valid_r <= '0;
			rd_data_r <= `FRS_BLANK;
		end else begin
			valid_r <= valid_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	// memory write port
	always_ff @(posedge aclk) begin
		if (lif.wr_en)
			mem_r[lif.wr_idx] <= lif.wr_data;
	end

	assign lif.rd_data = rd_data_r;
endmodule
`default_nettype wire

// ==== region_check.sv ====
// permission decode for the alternate region
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_regs.svh"
module region_check (
	input wire logic [14:0] addr,
	output logic rd_ok,
	output logic wr_ok
);
	logic [15:0] full; // alternate region sits at the top half

	// inclusive range test
	function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	// unlisted addresses give no access at all
	always_comb begin
		full = {1'b1, addr};
		wr_ok = in_rng(full, `FRS_UID_LO, `FRS_UID_HI) ||
			in_rng(full, `FRS_EE_LO, `FRS_EE_HI);
		rd_ok = wr_ok || in_rng(full, `FRS_ID_LO, `FRS_ID_HI) ||
			in_rng(full, `FRS_CFG_LO, `FRS_CFG_HI) ||
			in_rng(full, `FRS_INFO_LO, `FRS_INFO_HI);
	end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking testbench of the row write sequencer
`timescale 1ns/10ps
`default_nettype none
`include "flash_seq_regs.svh"
module tb_top;
	localparam logic [8:0] ROW = 9'h005; // unprotected row under test
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic awvalid, wvalid, bready, arvalid, rready, flash_done;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [8:0] wp_rows;
	logic [14:0] flash_addr;
	logic flash_region, flash_wr, flash_erase, flash_rd;
	logic [13:0] flash_wdata, flash_rdata, rd_val, d, e;
	logic [2:0] pend; // done delay line of the array stand-in
	logic [47:0] exp_q[$]; // notes of expected results, oldest first
	logic [13:0] lat[64]; // expected latch contents
	logic [15:0] alt_a[14] = '{16'h8000, 16'h8003, 16'h8004, 16'h8005, 16'h8006, 16'h8007,
		16'h800B, 16'h800C, 16'h8100, 16'h82FF, 16'h8300, 16'hF000, 16'hF0FF, 16'hF100};
	logic ok;
	int n_mismatch = 0;
	int samples_checked = 0;
	integer seed = 32'h26D7;

	// 100 MHz clock
	always #5 aclk = ~aclk;

	flash_row_write_sequencer flash_row_write_sequencer_inst (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(awaddr), .s_awprot(3'h0), .s_awvalid(awvalid), .s_awready(awready),
		.s_wdata(wdata), .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
		.s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
		.s_arprot(3'h0), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .wp_rows(wp_rows),
		.flash_addr(flash_addr), .flash_region(flash_region), .flash_wdata(flash_wdata),
		.flash_wr(flash_wr), .flash_erase(flash_erase), .flash_rd(flash_rd),
		.flash_done(flash_done), .flash_rdata(flash_rdata));

	// array stand-in: done four cycles after each pulse; read data only valid with done
	always @(posedge aclk) begin
		pend <= {pend[1:0], flash_wr | flash_erase | flash_rd};
		flash_done <= pend[2];
		flash_rdata <= pend[2] ? rd_val : ~rd_val;
	end

	// compare one observed result with the oldest note
	task automatic chk(input logic [47:0] obs);
		logic [47:0] n;
		samples_checked++;
		n = (exp_q.size() > 0) ? exp_q.pop_front() : ~obs;
		if (n !== obs) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, obs, n);
		end
	endtask

	// watcher: every result at the ports takes the oldest note
	always @(posedge aclk) begin
		if (aresetn && rvalid === 1'b1 && rready)
			chk({4'h0, 10'h000, rresp, rdata});
		if (aresetn && bvalid === 1'b1 && bready)
			chk({4'h1, 42'h0, bresp});
		if (flash_wr === 1'b1)
			chk({4'h2, 14'h0000, flash_region, flash_addr, flash_wdata});
		if (flash_erase === 1'b1)
			chk({4'h3, 14'h0000, flash_region, flash_addr, 14'h0000});
		if (flash_rd === 1'b1)
			chk({4'h4, 14'h0000, flash_region, flash_addr, 14'h0000});
	end

	// bus write; address and data offered together, each released when taken
	task automatic wr(input logic [5:0] a, input logic [7:0] v, input logic [1:0] r = 2'h0);
		exp_q.push_back({4'h1, 42'h0, r});
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	// bus read with expected low byte and response
	task automatic rd(input logic [5:0] a, input logic [7:0] v, input logic [1:0] r = 2'h0);
		exp_q.push_back({4'h0, 10'h000, r, 24'h000000, v});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask

	// address and data register pairs
	task automatic setad(input logic [14:0] a, input logic [13:0] v);
		wr(`FRS_OFF_ADDR_LO, a[7:0]);
		wr(`FRS_OFF_ADDR_HI, {1'b0, a[14:8]});
		wr(`FRS_OFF_DATA_LO, v[7:0]);
		wr(`FRS_OFF_DATA_HI, {2'h0, v[13:8]});
	endtask

	// full unlock then the control write
	task automatic go(input logic [7:0] c);
		wr(`FRS_OFF_KEY, `FRS_KEY_FIRST);
		wr(`FRS_OFF_KEY, `FRS_KEY_SECOND);
		wr(`FRS_OFF_CTRL, c);
	endtask

	// wait until every noted flash event was seen, then let the operation close
	task automatic drain;
		while (exp_q.size() != 0) @(posedge aclk);
		repeat (8) @(posedge aclk);
	endtask

	// latch-only load; no flash activity expected
	task automatic load(input logic [14:0] a);
		d = 14'($random(seed));
		setad(a, d);
		go(8'h26);
		lat[a[5:0]] = d;
	endtask

	// row program: all 64 latches into the row, then latches blank
	task automatic prog(input logic [8:0] row);
		d = 14'($random(seed));
		setad({row, `FRS_LAST_IDX}, d);
		go(8'h06);
		lat[63] = d;
		for (int i = 0; i < 64; i++) begin
			exp_q.push_back({4'h2, 14'h0000, 1'b0, row, 6'(i), lat[i]});
			lat[i] = `FRS_BLANK;
		end
		drain;
		rd(`FRS_OFF_CTRL, 8'h04);
	endtask

	// closing verdict
	task automatic stop_test;
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// watchdog against a hang
	initial begin
		repeat (40000) @(posedge aclk);
		n_mismatch++;
		stop_test;
	end

	// main sequence
	initial begin
		awaddr = 6'h00;
		araddr = 6'h00;
		wdata = 32'h00000000;
		{awvalid, wvalid, bready, arvalid, rready, flash_done} = 6'h00;
		pend = 3'h0;
		rd_val = 14'h0000;
		wp_rows = 9'h004; // rows 0..3 protected
		for (int i = 0; i < 64; i++) lat[i] = `FRS_BLANK;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`FRS_OFF_CTRL, 8'h00);
		rd(`FRS_OFF_ADDR_HI, 8'h80);
		rd(6'h18, 8'h00, 2'h2);
		wr(6'h18, 8'h00, 2'h2);
		// start bit without keys: ignored, no flag
		setad({ROW, 6'h01}, 14'h1234);
		wr(`FRS_OFF_CTRL, 8'h26);
		rd(`FRS_OFF_CTRL, 8'h24);
		// broken after first and after second key
		for (int k = 0; k < 2; k++) begin
			wr(`FRS_OFF_KEY, `FRS_KEY_FIRST);
			if (k == 1) wr(`FRS_OFF_KEY, `FRS_KEY_SECOND);
			wr(`FRS_OFF_DATA_LO, 8'h5A);
			rd(`FRS_OFF_CTRL, 8'h2C);
			wr(`FRS_OFF_CTRL, 8'h24);
		end
		load({ROW, 6'h00});
		load({ROW, 6'h05});
		load({9'h002, 6'h07});
		rd(`FRS_OFF_CTRL, 8'h24);
		prog(ROW);
		prog(9'h1FF);
		// program aimed at a protected row: refused, flag up, start bit down
		d = 14'($random(seed));
		setad({9'h003, `FRS_LAST_IDX}, d);
		go(8'h06);
		lat[63] = d;
		rd(`FRS_OFF_CTRL, 8'h0C);
		wr(`FRS_OFF_CTRL, 8'h04);
		// erase aimed at a protected row: refused, flag up, erase bit left set
		setad({9'h001, 6'h00}, 14'h0000);
		go(8'h16);
		rd(`FRS_OFF_CTRL, 8'h1C);
		wr(`FRS_OFF_CTRL, 8'h04);
		// read a word of the row back before it is erased, as an edit would
		rd_val = 14'($random(seed));
		setad({ROW, 6'h03}, 14'h0000);
		wr(`FRS_OFF_CTRL, 8'h05);
		exp_q.push_back({4'h4, 14'h0000, 1'b0, ROW, 6'h03, 14'h0000});
		drain;
		rd(`FRS_OFF_DATA_LO, rd_val[7:0]);
		rd(`FRS_OFF_DATA_HI, {2'h0, rd_val[13:8]});
		// erase one row from a mid-row address; latches blank afterwards
		load({ROW, 6'h09});
		setad({ROW, 6'h11}, 14'h0000);
		go(8'h16);
		exp_q.push_back({4'h3, 14'h0000, 1'b0, ROW, 6'h00, 14'h0000});
		for (int i = 0; i < 64; i++) lat[i] = `FRS_BLANK;
		drain;
		rd(`FRS_OFF_CTRL, 8'h04);
		// one-edge reset while an erase runs: the reset sets the error flag
		setad({ROW, 6'h00}, 14'h0000);
		go(8'h16);
		exp_q.push_back({4'h3, 14'h0000, 1'b0, ROW, 6'h00, 14'h0000});
		@(posedge aclk);
		aresetn <= 1'b0;
		@(posedge aclk);
		aresetn <= 1'b1;
		rd(`FRS_OFF_CTRL, 8'h08);
		wr(`FRS_OFF_CTRL, 8'h00);
		prog(ROW);
		// alternate region reads at range boundaries
		for (int i = 0; i < 14; i++) begin
			ok = (alt_a[i] >= 16'h8000 && alt_a[i] <= 16'h800B && alt_a[i] != 16'h8004) ||
				(alt_a[i] >= 16'h8100 && alt_a[i] <= 16'h82FF) ||
				(alt_a[i] >= 16'hF000 && alt_a[i] <= 16'hF0FF);
			rd_val = 14'($random(seed));
			setad(alt_a[i][14:0], 14'h2AAA);
			wr(`FRS_OFF_CTRL, 8'h41);
			if (ok) exp_q.push_back({4'h4, 14'h0000, 1'b1, alt_a[i][14:0], 14'h0000});
			drain;
			e = ok ? rd_val : 14'h0000;
			rd(`FRS_OFF_DATA_LO, e[7:0]);
			rd(`FRS_OFF_DATA_HI, {2'h0, e[13:8]});
		end
		// alternate region writes at the same boundaries
		for (int i = 0; i < 14; i++) begin
			ok = (alt_a[i] >= 16'h8000 && alt_a[i] <= 16'h8003) ||
				(alt_a[i] >= 16'hF000 && alt_a[i] <= 16'hF0FF);
			d = 14'($random(seed));
			setad(alt_a[i][14:0], d);
			go(8'h46);
			if (ok) exp_q.push_back({4'h2, 14'h0000, 1'b1, alt_a[i][14:0], d});
			drain;
			rd(`FRS_OFF_CTRL, ok ? 8'h44 : 8'h4C);
			if (!ok) wr(`FRS_OFF_CTRL, 8'h44);
		end
		stop_test;
	end
endmodule
`default_nettype wire
